// ### gpc_pad_ctl.v
// Per-pin output driver and pull-high control for one I/O pin
`timescale 1ns/1ps
`include "gpc_regs.vh"
module gpc_pad_ctl (
	input  wire       clk,
	input  wire       rst_b,
	input  wire [1:0] mode,
	input  wire       latch,
	input  wire       pin_hi,
	output reg        pad_o,
	output reg        pad_oe,
	output reg        pu_vweak,
	output reg        pu_weak,
	output reg        pu_strong
);
	reg       latch_old_q;
	reg [1:0] cnt_q;
	reg [1:0] cnt_d;
	reg       o_d;
	reg       oe_d;
	reg       vw_d;
	reg       wk_d;

	always @* begin
		cnt_d = (cnt_q != 2'd0) ? cnt_q - 2'd1 : 2'd0;
		o_d   = 1'b0;
		oe_d  = 1'b0;
		vw_d  = 1'b0;
		wk_d  = 1'b0;
		case (mode)
		`GPC_MODE_QUASI: begin
			oe_d = ~latch;
			vw_d = latch;
			wk_d = latch & pin_hi;
			if (latch & ~latch_old_q)
				cnt_d = `GPC_STRONG_PU_CLKS;
		end
		`GPC_MODE_PUSHPULL: begin
			oe_d = 1'b1;
			o_d  = latch;
		end
		`GPC_MODE_OPENDRAIN: begin
			oe_d = ~latch;
		end
		default: begin
			oe_d = 1'b0;
		end
		endcase
		if (mode != `GPC_MODE_QUASI)
			cnt_d = 2'd0;
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			latch_old_q <= 1'b1;
			cnt_q       <= 2'd0;
			pad_o       <= 1'b0;
			pad_oe      <= 1'b0;
			pu_vweak    <= 1'b0;
			pu_weak     <= 1'b0;
			pu_strong   <= 1'b0;
		end else begin
			latch_old_q <= latch;
			cnt_q       <= cnt_d;
			pad_o       <= o_d;
			pad_oe      <= oe_d;
			pu_vweak    <= vw_d;
			pu_weak     <= wk_d;
			pu_strong   <= (cnt_d != 2'd0);
		end
	end
endmodule

// ### gpc_pins_model.sv
// Outside world on the port pins: drivers and resistors
`timescale 1ns/1ps
module gpc_pins_model #(
	parameter NPIN = 16
) (
	input  wire [NPIN-1:0] pad_o,
	input  wire [NPIN-1:0] pad_oe,
	input  wire [NPIN-1:0] ext_en,
	input  wire [NPIN-1:0] ext_val,
	output wire [NPIN-1:0] pad_i
);
	// Strong drive wins; an outside driver beats the weak pulls; an idle pin rests on a resistor to supply
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & ((ext_en & ext_val) | ~ext_en));
endmodule

// ### gpc_port.v
// GPIO ports 0 to 2: latches for ports 0 and 1 only, SFR reads, mode decode and pad control
`timescale 1ns/1ps
`include "gpc_regs.vh"
module gpc_port #(
	parameter NPIN       = 16,
	parameter DBG_HOLD   = `GPC_DBG_HOLD_SLOW,
	parameter DBG_DATA_I = 6,
	parameter DBG_CLK_I  = 8
) (
	input  wire            clk,
	input  wire            rst_b,
	// Core SFR port
	input  wire [7:0]      sfr_addr,
	input  wire            sfr_wr,
	input  wire [7:0]      sfr_wdata,
	input  wire            sfr_rd,
	input  wire            sfr_rmw,
	output reg  [7:0]      sfr_rdata,
	output reg             sfr_rvalid,
	// Core bit-addressed port
	input  wire [7:0]      bit_addr,
	input  wire            bit_wr,
	input  wire            bit_wdata,
	input  wire            bit_rd,
	input  wire            bit_rmw,
	output reg             bit_rdata,
	output reg             bit_rvalid,
	// Configuration levels, port 1 in the upper byte
	input  wire [NPIN-1:0] mode_sel_a,
	input  wire [NPIN-1:0] mode_sel_b,
	input  wire [NPIN-1:0] schmitt_select,
	input  wire [NPIN-1:0] slew_fast_select,
	input  wire            reset_pin_disable,
	input  wire            pin20_pullup_en,
	// Slow oscillator, counted for the debug pin window
	input  wire            low_speed_rc_osc,
	// Port 0 and port 1 pads
	input  wire [NPIN-1:0] pad_i,
	output wire [NPIN-1:0] pad_o,
	output wire [NPIN-1:0] pad_oe,
	output wire [NPIN-1:0] pad_pu_vweak,
	output wire [NPIN-1:0] pad_pu_weak,
	output wire [NPIN-1:0] pad_pu_strong,
	output reg  [NPIN-1:0] pad_schmitt_en,
	output reg  [NPIN-1:0] pad_slew_fast,
	// Reset-shared pin
	input  wire            reset_shared_pin_i,
	output reg             reset_shared_pin_pu,
	output reg             reset_shared_pin_schmitt,
	output reg             reset_shared_pin_is_reset
);
	localparam SW = NPIN + 2;

	wire [SW-1:0]   sync_w;
	wire [NPIN-1:0] pin_s;
	wire            rpin_s;
	wire            osc_s;

	reg [7:0]       port0_data_latch_q;
	reg [7:0]       port1_data_latch_q;
	reg [7:0]       port0_d;
	reg [7:0]       port1_d;
	wire [NPIN-1:0] latch_w;

	reg             osc_old_q;
	reg [9:0]       hold_cnt_q;
	reg             hold_q;

	reg [1:0]       eff_mode [0:NPIN-1];
	reg [7:0]       rd_byte_d;
	reg             rd_bit_d;
	reg [7:0]       bit_byte;
	integer         i;

	// Pad, reset-pin and slow oscillator levels are synchronised before any logic reads them
	gpc_sync #(
		.W (SW)
	) u_sync (
		.clk     (clk),
		.rst_b   (rst_b),
		.async_i ({low_speed_rc_osc, reset_shared_pin_i, pad_i}),
		.sync_o  (sync_w)
	);

	assign pin_s  = sync_w[NPIN-1:0];
	assign rpin_s = sync_w[NPIN];
	assign osc_s  = sync_w[NPIN+1];

	assign latch_w = {port1_data_latch_q, port0_data_latch_q};

	// Window after reset, counted in slow oscillator edges
	always @(posedge clk) begin
		if (!rst_b) begin
			osc_old_q  <= 1'b0;
			hold_cnt_q <= 10'd0;
			hold_q     <= 1'b1;
		end else begin
			osc_old_q <= osc_s;
			if (hold_q && osc_s && !osc_old_q) begin
				if (hold_cnt_q == DBG_HOLD - 1)
					hold_q <= 1'b0;
				hold_cnt_q <= hold_cnt_q + 10'd1;
			end
		end
	end

	// Effective mode: forced during the window, software choice after
	always @* begin
		for (i = 0; i < NPIN; i = i + 1) begin
			if (hold_q) begin
				if (i == DBG_DATA_I || i == DBG_CLK_I)
					eff_mode[i] = `GPC_MODE_QUASI;
				else
					eff_mode[i] = `GPC_MODE_INPUT;
			end else begin
				eff_mode[i] = {mode_sel_a[i], mode_sel_b[i]};
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_pad
			gpc_pad_ctl u_pad (
				.clk       (clk),
				.rst_b     (rst_b),
				.mode      (eff_mode[g]),
				.latch     (latch_w[g]),
				.pin_hi    (pin_s[g]),
				.pad_o     (pad_o[g]),
				.pad_oe    (pad_oe[g]),
				.pu_vweak  (pad_pu_vweak[g]),
				.pu_weak   (pad_pu_weak[g]),
				.pu_strong (pad_pu_strong[g])
			);
		end
	endgenerate

	// Byte the bit port addresses, taken from the latch
	always @* begin
		case (bit_addr & `GPC_BIT_PORT_MASK)
		`GPC_PORT0_ADDR: bit_byte = port0_data_latch_q;
		`GPC_PORT1_ADDR: bit_byte = port1_data_latch_q;
		default:         bit_byte = 8'h00;
		endcase
		bit_byte[bit_addr[2:0]] = bit_wdata;
	end

	// Latch update; a byte write wins over a bit write in the same cycle
	always @* begin
		port0_d = port0_data_latch_q;
		port1_d = port1_data_latch_q;
		if (sfr_wr) begin
			if (sfr_addr == `GPC_PORT0_ADDR)
				port0_d = sfr_wdata;
			if (sfr_addr == `GPC_PORT1_ADDR)
				port1_d = sfr_wdata;
		end else if (bit_wr) begin
			if ((bit_addr & `GPC_BIT_PORT_MASK) == `GPC_PORT0_ADDR)
				port0_d = bit_byte;
			if ((bit_addr & `GPC_BIT_PORT_MASK) == `GPC_PORT1_ADDR)
				port1_d = bit_byte;
		end
	end

	always @(posedge clk) begin
		if (!rst_b) begin
			port0_data_latch_q <= `GPC_PORT_RESET;
			port1_data_latch_q <= `GPC_PORT_RESET;
		end else begin
			port0_data_latch_q <= port0_d;
			port1_data_latch_q <= port1_d;
		end
	end

	// Read data: pins normally, latch for the read phase of RMW
	always @* begin
		case (sfr_addr)
		`GPC_PORT0_ADDR: rd_byte_d = sfr_rmw ? port0_data_latch_q : pin_s[7:0];
		`GPC_PORT1_ADDR: rd_byte_d = sfr_rmw ? port1_data_latch_q : pin_s[15:8];
		`GPC_PORT2_ADDR: rd_byte_d = {7'h00, rpin_s & ~reset_pin_disable};
		default:         rd_byte_d = 8'h00;
		endcase
	end

	always @* begin
		case (bit_addr & `GPC_BIT_PORT_MASK)
		`GPC_PORT0_ADDR: rd_bit_d = bit_rmw ? port0_data_latch_q[bit_addr[2:0]] : pin_s[bit_addr[2:0]];
		`GPC_PORT1_ADDR: rd_bit_d = bit_rmw ? port1_data_latch_q[bit_addr[2:0]] : pin_s[{1'b1, bit_addr[2:0]}];
		`GPC_PORT2_ADDR: rd_bit_d = (bit_addr[2:0] == 3'd0) & rpin_s & ~reset_pin_disable;
		default:         rd_bit_d = 1'b0;
		endcase
	end

	// Answers come one cycle after the strobe, from flops
	always @(posedge clk) begin
		if (!rst_b) begin
			sfr_rdata  <= 8'h00;
			sfr_rvalid <= 1'b0;
			bit_rdata  <= 1'b0;
			bit_rvalid <= 1'b0;
		end else begin
			sfr_rvalid <= sfr_rd;
			bit_rvalid <= bit_rd;
			if (sfr_rd)
				sfr_rdata <= rd_byte_d;
			if (bit_rd)
				bit_rdata <= rd_bit_d;
		end
	end

	// Input buffer type, slew, and reset-shared pin control
	always @(posedge clk) begin
		if (!rst_b) begin
			pad_schmitt_en            <= {NPIN{1'b0}};
			pad_slew_fast             <= {NPIN{1'b0}};
			reset_shared_pin_pu       <= 1'b1;
			reset_shared_pin_schmitt  <= 1'b1;
			reset_shared_pin_is_reset <= 1'b1;
		end else begin
			pad_schmitt_en <= schmitt_select;
			pad_slew_fast  <= slew_fast_select;
			reset_shared_pin_schmitt  <= 1'b1;
			reset_shared_pin_is_reset <= reset_pin_disable;
			// Pull-up stays on as a reset input so the line cannot float low
			reset_shared_pin_pu <= reset_pin_disable | pin20_pullup_en;
		end
	end
endmodule

// ### gpc_port_asserts.sv
// Concurrent checks on the GPIO port block's ports
`timescale 1ns/1ps
module gpc_chk #(
	parameter NPIN = 16
) (
	input wire            clk,
	input wire            rst_b,
	input wire            sfr_rd,
	input wire [7:0]      sfr_addr,
	input wire [7:0]      sfr_rdata,
	input wire            sfr_rvalid,
	input wire [NPIN-1:0] mode_sel_a,
	input wire [NPIN-1:0] mode_sel_b,
	input wire [NPIN-1:0] schmitt_select,
	input wire [NPIN-1:0] pad_schmitt_en,
	input wire            reset_pin_disable,
	input wire            pin20_pullup_en,
	input wire            reset_shared_pin_pu,
	input wire [NPIN-1:0] pad_o,
	input wire [NPIN-1:0] pad_oe,
	input wire [NPIN-1:0] pad_pu_vweak,
	input wire [NPIN-1:0] pad_pu_weak,
	input wire [NPIN-1:0] pad_pu_strong
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_rvalid; sfr_rd |=> sfr_rvalid; endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_port2; sfr_rd && sfr_addr == 8'ha0 |=> sfr_rdata[7:1] == 7'h00; endproperty
	a_port2: assert property (p_port2) else $error("port 2 upper bits set");
	// Register takes a cycle, so only settled config is judged
	property p_rpin_gp; $past(rst_b) && !reset_pin_disable && $stable(pin20_pullup_en) && $stable(reset_pin_disable)
		|-> reset_shared_pin_pu == pin20_pullup_en; endproperty
	a_rpin_gp: assert property (p_rpin_gp) else $error("reset pin pull-up wrong");
	property p_rpin_rst; reset_pin_disable && $past(reset_pin_disable) |-> reset_shared_pin_pu; endproperty
	a_rpin_rst: assert property (p_rpin_rst) else $error("reset pin pull-up off");
	property p_input; $past(rst_b) && $past(mode_sel_a[2]) && !$past(mode_sel_b[2])
		|-> !(pad_oe[2] || pad_pu_vweak[2] || pad_pu_weak[2] || pad_pu_strong[2]); endproperty
	a_input: assert property (p_input) else $error("input pin drives");
	property p_odrain; $past(rst_b) && $past(mode_sel_a[3]) && $past(mode_sel_b[3])
		|-> !(pad_o[3] || pad_pu_vweak[3] || pad_pu_weak[3] || pad_pu_strong[3]); endproperty
	a_odrain: assert property (p_odrain) else $error("open-drain pin pulls high");
	property p_pushpull; pad_oe[0] && pad_o[0] |-> !$past(mode_sel_a[0]) && $past(mode_sel_b[0]); endproperty
	a_pushpull: assert property (p_pushpull) else $error("strong high outside push-pull");
	property p_strong; $rose(pad_pu_strong[1]) |=> pad_pu_strong[1] ##1 !pad_pu_strong[1]; endproperty
	a_strong: assert property (p_strong) else $error("strong pull-high not two cycles");
	property p_weak; pad_pu_weak[1] |-> pad_pu_vweak[1] && !$past(mode_sel_a[1]) && !$past(mode_sel_b[1]); endproperty
	a_weak: assert property (p_weak) else $error("weak pull-high out of place");
	property p_schmitt; $past(rst_b) |-> pad_schmitt_en == $past(schmitt_select); endproperty
	a_schmitt: assert property (p_schmitt) else $error("input type not mirrored");
	c_port2: cover property (sfr_rd && sfr_addr == 8'ha0);
	c_strong: cover property ($rose(pad_pu_strong[1]));
	c_weak: cover property (pad_pu_weak[1]);
endmodule

// ### gpc_port_bench.sv
// Self-checking bench for the GPIO port block
`timescale 1ns/1ps
module gpc_port_bench;
	reg         clk = 1'b0;
	reg         rst_b = 1'b0;
	reg  [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, bit_addr = 8'h00;
	reg         sfr_wr = 0, sfr_rd = 0, sfr_rmw = 0, bit_wr = 0, bit_wdata = 0, bit_rd = 0, bit_rmw = 0;
	reg         reset_pin_disable = 1, pin20_pullup_en = 0, low_speed_rc_osc = 0, reset_shared_pin_i = 1;
	reg  [15:0] mode_sel_a = 16'hfffc, mode_sel_b = 16'h0009, schmitt_select = 0, slew_fast_select = 0;
	reg  [15:0] ext_en = 0, ext_val = 0;
	reg  [3:0]  oc = 0;
	wire [7:0]  sfr_rdata;
	wire        sfr_rvalid, bit_rdata, bit_rvalid;
	wire        reset_shared_pin_pu, reset_shared_pin_schmitt, reset_shared_pin_is_reset;
	wire [15:0] pad_i, pad_o, pad_oe, pad_pu_vweak, pad_pu_weak, pad_pu_strong, pad_schmitt_en, pad_slew_fast;
	integer     err_total = 0, checks_done = 0, n;

	gpc_port #(.DBG_HOLD(4)) gpc_port_i (.*);
	gpc_pins_model gpc_pins_model_i (.pad_o(pad_o), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val), .pad_i(pad_i));

	always #12.5 clk = ~clk;
	// Slow oscillator at a sixteenth of the clock keeps the debug window short
	always @(negedge clk) begin
		oc <= oc + 4'h1;
		low_speed_rc_osc <= oc[3];
	end

	task chk(input [15:0] g, input [15:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				err_total = err_total + 1;
				$display("Error at %0t: got %h expected %h", $time, g, e);
			end
		end
	endtask

	task wr(input b, input [7:0] a, input [7:0] d);
		begin
			@(negedge clk);
			sfr_addr = a;
			bit_addr = a;
			sfr_wdata = d;
			bit_wdata = d[0];
			sfr_wr = !b;
			bit_wr = b;
			@(negedge clk);
			sfr_wr = 0;
			bit_wr = 0;
		end
	endtask

	task rd(input b, input [7:0] a, input m, input [7:0] e);
		begin
			@(negedge clk);
			sfr_addr = a;
			bit_addr = a;
			sfr_rmw = m;
			bit_rmw = m;
			sfr_rd = !b;
			bit_rd = b;
			@(negedge clk);
			sfr_rd = 0;
			bit_rd = 0;
			chk({b ? bit_rvalid : sfr_rvalid, b ? {7'h00, bit_rdata} : sfr_rdata}, {1'b1, e});
		end
	endtask

	task report(input [63:0] s);
		$display("Test %0s done, mismatches so far %0d", s, err_total);
	endtask

	task summarize;
		begin
			$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	initial begin
		repeat (3) @(negedge clk);
		rst_b = 1;
		repeat (8) @(negedge clk);
		chk({pad_pu_vweak[6], pad_oe[0]}, 2'b10);
		rd(0, 8'h80, 1, 8'hff);
		rd(0, 8'h90, 1, 8'hff);
		chk(pad_slew_fast, 16'h0000);
		repeat (100) @(negedge clk);
		chk({pad_pu_vweak[6], pad_oe[0], pad_o[0]}, 3'b011);
		report("reset");
		ext_en = 16'h000c;
		wr(0, 8'h80, 8'h0a);
		repeat (4) @(negedge clk);
		rd(0, 8'h80, 0, 8'hf2);
		rd(0, 8'h80, 1, 8'h0a);
		chk({pad_pu_vweak[1], pad_pu_weak[1]}, 2'b11);
		ext_en[1] = 1'b1;
		repeat (4) @(negedge clk);
		chk({pad_pu_vweak[1], pad_pu_weak[1]}, 2'b10);
		ext_en[1] = 1'b0;
		wr(1, 8'h81, 8'h00);
		@(negedge clk);
		chk({pad_oe[1], pad_o[1]}, 2'b10);
		wr(1, 8'h81, 8'h01);
		n = 0;
		repeat (6) begin
			@(negedge clk);
			n = n + pad_pu_strong[1];
		end
		chk(n[15:0], 16'h0002);
		report("quasi");
		wr(1, 8'h97, 8'h00);
		rd(0, 8'h90, 1, 8'h7f);
		rd(1, 8'h97, 1, 8'h00);
		repeat (4) @(negedge clk);
		rd(1, 8'h97, 0, 8'h01);
		report("bits");
		rd(0, 8'ha0, 0, 8'h00);
		chk({reset_shared_pin_pu, reset_shared_pin_is_reset}, 2'b11);
		reset_pin_disable = 0;
		wr(0, 8'ha0, 8'hfe);
		repeat (4) @(negedge clk);
		rd(0, 8'ha0, 0, 8'h01);
		rd(1, 8'ha0, 0, 8'h01);
		chk({reset_shared_pin_pu, reset_shared_pin_schmitt, reset_shared_pin_is_reset}, 3'b010);
		report("port2");
		schmitt_select = 16'ha5c3;
		slew_fast_select = 16'h3c5a;
		repeat (2) @(negedge clk);
		chk(pad_schmitt_en, 16'ha5c3);
		chk(pad_slew_fast, 16'h3c5a);
		report("inputs");
		summarize;
	end

	initial begin
		#200000;
		err_total = err_total + 1;
		summarize;
	end
endmodule

bind gpc_port gpc_chk #(.NPIN(NPIN)) gpc_chk_i (.*);

// ### gpc_regs.vh
// Register offsets, reset values and timing counts of the GPIO port block
`ifndef GPC_REGS_VH
`define GPC_REGS_VH

`define GPC_PORT0_ADDR      8'h80
`define GPC_PORT1_ADDR      8'h90
`define GPC_PORT2_ADDR      8'ha0
`define GPC_PORT_RESET      8'hff
`define GPC_BIT_PORT_MASK   8'hf8
`define GPC_BIT_IDX_MASK    8'h07
`define GPC_PORT2_PIN_BIT   0

`define GPC_MODE_QUASI      2'b00
`define GPC_MODE_PUSHPULL   2'b01
`define GPC_MODE_INPUT      2'b10
`define GPC_MODE_OPENDRAIN  2'b11

`define GPC_DBG_HOLD_SLOW   600
`define GPC_STRONG_PU_CLKS  2'd2

`endif

// ### gpc_sync.v
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module gpc_sync #(
	parameter W = 1
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] async_i,
	output wire [W-1:0] sync_o
);
	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	always @(posedge clk) begin
		if (!rst_b) begin
			meta_q <= {W{1'b0}};
			sync_q <= {W{1'b0}};
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;
endmodule
